// ==== include/fsa_defines.vh ====
// Purpose: Shared constants for the fault supervisor and alert block.
// Assumes: Plain Verilog-2005, included by bare name.
// Notes: Bit positions index the status and fault flag vectors.
`ifndef FSA_DEFINES_VH
`define FSA_DEFINES_VH

`define FSA_ST_OV           0
`define FSA_ST_UV           1
`define FSA_ST_OC           2
`define FSA_ST_PWRBAD       3
`define FSA_ST_EN           4
`define FSA_ST_SHORT        5
`define FSA_ST_GPIN         6

`define FSA_FL_OV           0
`define FSA_FL_UV           1
`define FSA_FL_OC           2
`define FSA_FL_PWRBAD       3
`define FSA_FL_ENCHG        4
`define FSA_FL_SHORT        5
`define FSA_FL_GPIN         6
`define FSA_FL_EXT          7

`define FSA_ADDR_STATUS     2'h0
`define FSA_ADDR_FAULT      2'h1
`define FSA_ADDR_ALERT      2'h2
`define FSA_ADDR_CONTROL    2'h3

`define FSA_RST_ALERT_EN    8'h00
`define FSA_RST_CONTROL     8'h00
`define FSA_CTL_OV_RETRY    0
`define FSA_CTL_UV_RETRY    1
`define FSA_CTL_OC_RETRY    2
`define FSA_CTL_FET_ON      3
`define FSA_CTL_PB_RETRY    4
`define FSA_CTL_GPIN_MODE   5

`define FSA_BASE_DELAY_CYC  1000
`define FSA_SHORT_THRESH    10'h020

`endif

// ==== design/fsa_sync.v ====
// Purpose: Two-flop synchroniser for a vector of asynchronous levels.
// Assumes: Inputs are slow levels relative to sys_clk.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module fsa_sync #(
	parameter W     = 8,
	parameter RSTV  = 0
) (
	input  wire         sys_clk,
	input  wire         sys_rst,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_r;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r   <= RSTV[W-1:0];
			sync_out <= RSTV[W-1:0];
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // fsa_sync
`default_nettype wire

// ==== design/fsa_delay_timer.v ====
// Purpose: Counts one or four base delay periods and pulses on expiry.
// Assumes: start is a one-cycle pulse; a new start restarts the count.
// Notes: abort drops a running count without a done pulse.
`timescale 1ns/1ps
`default_nettype none
module fsa_delay_timer #(
	parameter BASE = 1000
) (
	input  wire sys_clk,
	input  wire sys_rst,
	input  wire start,
	input  wire quad,
	input  wire abort,
	output reg  busy,
	output reg  done
);
	reg [31:0] cnt_r;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_r <= 32'h0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_r <= quad ? (4 * BASE) - 1 : BASE - 1;
				busy  <= 1'b1;
			end else if (abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (cnt_r == 32'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 32'h1;
				end
			end
		end
	end
endmodule // fsa_delay_timer
`default_nettype wire

// ==== design/fsa_supervisor.v ====
// Purpose: Fault supervision, fault flags, alert output and FET-on gating.
// Assumes: sys_clk 40 MHz, synchronous active-high reset as power-on reset.
// Notes: Comparator results arrive as digital levels from the analog side.
// Functional notes
// - UV output changes only when both UV comparators agree.
// - UV condition turns FET off, sets uv status and fault, drops power good.
// - UV status clears on recovery; retry after one base delay if enabled.
// - UV present at supply lockout release logs a UV fault.
// - Sense reading at short threshold with FET off sets short flags.
// - Power good starts four-delay check; bad check input trips power-bad.
// - Power-bad status clears once off; retry when enabled or fault cleared.
// - Low external fault input sets its flag; own alert enable.
// - General input high sets gpin status and fault; no alert enable.
// - External fault inputs never touch FET control.
// - Fault flag asserts alert only when enabled; enables reset to zero.
// - Alert response address: reply own address, release alert.
// - Direct addressing by the host releases alert too.
// - After release alert stays high until a new fault edge.
// - Host writing zero to a fault bit clears it.
// - On or fet_on_ctrl falling clears all but present faults; supply lockout clears all faults.
// - UV reset level clears faults; recovery into UV band sets uv_fault.
// - Enable falling clears faults except enable change, which sets.
// - Faults with present condition cannot be cleared except by lockout or UV reset; no auto clear on retry.
// - Latched ov, uv, oc and power-bad faults hold FET off; release after one or four base delays.
// - Host clearing ov_fault allows immediate turn-on.
// - With auto-retry, present bits hold FET off, fault flags ignored.
// - On input edges set and clear fet_on_ctrl; host may write it.
// - enable_pin_state mirrors enable; change sets enable_change_fault.
// - Breaker expiry sets oc flags, FET off, oc status clears, retry 4 delays.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fsa_defines.vh"
module fsa_supervisor #(
	parameter BASE_DELAY = `FSA_BASE_DELAY_CYC,
	parameter [6:0] OWN_ADDR = 7'h40
) (
	input  wire       sys_clk,
	input  wire       sys_rst,
	input  wire       uv_rise_input,
	input  wire       uv_fall_input,
	input  wire       uv_reset_level,
	input  wire       ov_input,
	input  wire       supply_ok,
	input  wire       on_input,
	input  wire       enable_n,
	input  wire       good_check_in,
	input  wire       second_good_pin,
	input  wire       ext_fault_in,
	input  wire       breaker_expired,
	input  wire       sense_valid,
	input  wire [9:0] sense_reading,
	input  wire       ara_request,
	input  wire       direct_addressed,
	input  wire [1:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	output reg        fet_on,
	output reg        power_good_out,
	output reg        alert_n,
	output reg        ara_reply_valid,
	output reg  [6:0] ara_reply_addr
);
	localparam ST_OFF   = 2'h0;
	localparam ST_WAIT  = 2'h1;
	localparam ST_ON    = 2'h2;
	localparam ST_CHECK = 2'h3;

	wire [9:0] sy;
	fsa_sync #(.W(10), .RSTV(10'h287)) u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in ({ext_fault_in, second_good_pin, good_check_in, enable_n, on_input,
			supply_ok, ov_input, uv_reset_level, uv_fall_input, uv_rise_input}),
		.sync_out (sy)
	);
	wire s_uvh = sy[0];
	wire s_uvl = sy[1];
	wire s_uvr = sy[2];
	wire s_ov  = sy[3];
	wire s_sup = sy[4];
	wire s_on  = sy[5];
	wire s_en  = sy[6];
	wire s_pgi = sy[7];
	wire s_gp  = sy[8];
	wire s_flt = sy[9];

	reg  [7:0] status_r;
	reg  [7:0] fault_r;
	reg  [7:0] alert_en_r;
	reg  [7:0] control_r;
	reg  [7:0] alerted_r;
	reg        uv_r;
	reg        on_d_r;
	reg        en_d_r;
	reg        sup_d_r;
	reg        uvr_d_r;
	reg        fon_d_r;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg        ov_clr_r;
	reg        start_quad_r;
	reg  [7:0] fault_nxt;
	reg  [7:0] status_nxt;

	wire t_busy;
	wire t_done;
	reg  t_start;
	reg  t_quad;
	reg  t_abort;

	fsa_delay_timer #(.BASE(BASE_DELAY)) u_tmr (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.start   (t_start),
		.quad    (t_quad),
		.abort   (t_abort),
		.busy    (t_busy),
		.done    (t_done)
	);

	wire uv_enter = ~s_uvl & ~s_uvh;
	wire uv_leave = s_uvl & s_uvh;
	wire uv_now   = uv_enter ? 1'b1 : (uv_leave ? 1'b0 : uv_r);

	wire fet_ctl  = control_r[`FSA_CTL_FET_ON];
	wire on_fall  = on_d_r & ~s_on;
	wire on_rise  = ~on_d_r & s_on;
	wire fon_fall = fon_d_r & ~fet_ctl;
	wire en_fall  = en_d_r & ~s_en;
	wire en_chg   = en_d_r ^ s_en;
	wire sup_up   = ~sup_d_r & s_sup;
	wire uvr_up   = ~uvr_d_r & s_uvr;
	wire gp_mode  = control_r[`FSA_CTL_GPIN_MODE];
	wire wr_fault = reg_wr && (reg_addr == `FSA_ADDR_FAULT);
	wire wr_ctl   = reg_wr && (reg_addr == `FSA_ADDR_CONTROL);
	wire trip_pb  = (state_r == ST_CHECK) && t_done && s_pgi;
	wire trip_oc  = breaker_expired && fet_on;
	wire short_hit = sense_valid && !fet_on && (sense_reading >= `FSA_SHORT_THRESH);
	wire ov_clr_wr = wr_fault && !reg_wdata[`FSA_FL_OV] && fault_r[`FSA_FL_OV];

	// Permission to drive the gate, before any retry delay.
	reg permit;
	always @* begin
		permit = fet_ctl && !s_en && s_sup && !uv_now && !s_ov && !status_r[`FSA_ST_OC];
		if (status_r[`FSA_ST_PWRBAD])
			permit = 1'b0;
		if ((fault_r[`FSA_FL_OV] && !control_r[`FSA_CTL_OV_RETRY]) ||
			(fault_r[`FSA_FL_UV] && !control_r[`FSA_CTL_UV_RETRY]) ||
			(fault_r[`FSA_FL_OC] && !control_r[`FSA_CTL_OC_RETRY]) ||
			(fault_r[`FSA_FL_PWRBAD] && !control_r[`FSA_CTL_PB_RETRY]))
			permit = 1'b0;
	end

	always @* begin
		state_nxt = state_r;
		t_start   = 1'b0;
		t_quad    = 1'b0;
		t_abort   = 1'b0;
		case (state_r)
			ST_OFF: begin
				if (permit) begin
					if (ov_clr_r && !start_quad_r) begin
						state_nxt = ST_ON;
					end else begin
						state_nxt = ST_WAIT;
						t_start   = 1'b1;
						t_quad    = start_quad_r;
					end
				end
			end
			ST_WAIT: begin
				if (t_done) begin
					state_nxt = permit ? ST_ON : ST_OFF;
				end else if (!permit && !start_quad_r) begin
					state_nxt = ST_OFF;
					t_abort   = 1'b1;
				end
			end
			ST_ON: begin
				if (!permit) begin
					state_nxt = ST_OFF;
				end else begin
					state_nxt = ST_CHECK;
					t_start   = 1'b1;
					t_quad    = 1'b1;
				end
			end
			ST_CHECK: begin
				if (!permit || trip_pb || trip_oc) begin
					state_nxt = trip_oc || !permit || trip_pb ? ST_OFF : ST_CHECK;
					t_abort   = 1'b1;
				end
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	always @* begin
		status_nxt = status_r;
		fault_nxt  = fault_r;
		status_nxt[`FSA_ST_OV] = s_ov;
		status_nxt[`FSA_ST_EN] = s_en;
		status_nxt[`FSA_ST_UV] = uv_now;
		status_nxt[`FSA_ST_SHORT] = short_hit ? 1'b1 :
			(sense_valid ? 1'b0 : status_r[`FSA_ST_SHORT]);
		status_nxt[`FSA_ST_GPIN] = gp_mode & s_gp;
		// power-bad status clears once FET is off
		if (status_r[`FSA_ST_PWRBAD] && !fet_on)
			status_nxt[`FSA_ST_PWRBAD] = 1'b0;
		if (status_r[`FSA_ST_OC] && !fet_on)
			status_nxt[`FSA_ST_OC] = 1'b0;
		if (wr_fault)
			fault_nxt = fault_r & reg_wdata;
		if (on_fall || fon_fall)
			fault_nxt = 8'h00;
		if (en_fall)
			fault_nxt = 8'h00;
		fault_nxt = fault_nxt | (fault_r & status_r & 8'h6F);
		if (uv_now && !uv_r)
			fault_nxt[`FSA_FL_UV] = 1'b1;
		if (sup_up && uv_now)
			fault_nxt[`FSA_FL_UV] = 1'b1;
		if (uvr_up && !s_uvh && !s_uvl)
			fault_nxt[`FSA_FL_UV] = 1'b1;
		if (s_ov && s_sup)
			fault_nxt[`FSA_FL_OV] = 1'b1;
		status_nxt[`FSA_ST_OV] = s_ov;
		if (en_chg)
			fault_nxt[`FSA_FL_ENCHG] = 1'b1;
		if (short_hit)
			fault_nxt[`FSA_FL_SHORT] = 1'b1;
		if (trip_pb) begin
			status_nxt[`FSA_ST_PWRBAD] = 1'b1;
			fault_nxt[`FSA_FL_PWRBAD]  = 1'b1;
		end
		if (trip_oc) begin
			status_nxt[`FSA_ST_OC] = 1'b1;
			fault_nxt[`FSA_FL_OC]  = 1'b1;
		end
		if (!s_flt)
			fault_nxt[`FSA_FL_EXT] = 1'b1;
		if (gp_mode && s_gp)
			fault_nxt[`FSA_FL_GPIN] = 1'b1;
		if (!s_sup || !s_uvr)
			fault_nxt = 8'h00;
		status_nxt[7] = fet_on;
	end

	wire [7:0] alert_src = fault_r & alert_en_r & 8'hBF;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			status_r        <= 8'h00;
			fault_r         <= 8'h00;
			alert_en_r      <= `FSA_RST_ALERT_EN;
			control_r       <= `FSA_RST_CONTROL;
			alerted_r       <= 8'h00;
			uv_r            <= 1'b0;
			on_d_r          <= 1'b0;
			en_d_r          <= 1'b0;
			sup_d_r         <= 1'b0;
			uvr_d_r         <= 1'b1;
			fon_d_r         <= 1'b0;
			state_r         <= ST_OFF;
			ov_clr_r        <= 1'b0;
			start_quad_r    <= 1'b0;
			fet_on          <= 1'b0;
			power_good_out  <= 1'b0;
			alert_n         <= 1'b1;
			ara_reply_valid <= 1'b0;
			ara_reply_addr  <= 7'h00;
			reg_rdata       <= 8'h00;
		end else begin
			status_r  <= status_nxt;
			fault_r   <= fault_nxt;
			uv_r      <= uv_now;
			on_d_r    <= s_on;
			en_d_r    <= s_en;
			sup_d_r   <= s_sup;
			uvr_d_r   <= s_uvr;
			fon_d_r   <= fet_ctl;
			state_r   <= state_nxt;
			fet_on    <= (state_nxt == ST_ON) || (state_nxt == ST_CHECK);
			// power good drops with UV and trips
			power_good_out <= (state_nxt == ST_CHECK) || ((state_nxt == ST_ON) && power_good_out);
			if (trip_oc)
				start_quad_r <= 1'b1;
			else if (state_r == ST_ON)
				start_quad_r <= 1'b0;
			// The ov flag is only gone one cycle after the host clear, so remember it.
			ov_clr_r <= ov_clr_wr;
			if (reg_wr && reg_addr == `FSA_ADDR_ALERT)
				alert_en_r <= reg_wdata & 8'hBF;
			if (wr_ctl)
				control_r <= reg_wdata;
			if (on_rise)
				control_r[`FSA_CTL_FET_ON] <= 1'b1;
			else if (on_fall)
				control_r[`FSA_CTL_FET_ON] <= 1'b0;
			if (!s_sup)
				control_r[`FSA_CTL_FET_ON] <= 1'b0;
			// re-arm only when a flag is cleared
			alerted_r <= alerted_r & fault_nxt;
			ara_reply_valid <= ara_request && !alert_n;
			ara_reply_addr  <= OWN_ADDR;
			if ((ara_request && !alert_n) || direct_addressed) begin
				alerted_r <= alert_src & fault_nxt;
				alert_n   <= 1'b1;
			end else begin
				alert_n <= ~|(alert_src & ~alerted_r) & alert_n | ~|(alert_src & ~alerted_r);
			end
			if (reg_rd) begin
				case (reg_addr)
					`FSA_ADDR_STATUS:  reg_rdata <= status_r;
					`FSA_ADDR_FAULT:   reg_rdata <= fault_r;
					`FSA_ADDR_ALERT:   reg_rdata <= alert_en_r;
					`FSA_ADDR_CONTROL: reg_rdata <= control_r;
					default:           reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // fsa_supervisor
`default_nettype wire

// ==== verification/fsa_supervisor_properties.sv ====
// Purpose: Port-level checks for fsa_supervisor.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Pin inputs pass two sync flops, so levels are held five cycles before judging.
`timescale 1ns/1ps
`default_nettype none
module fsa_sva #(
	parameter [6:0] OWN_ADDR = 7'h40
) (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       uv_rise_input,
	input wire logic       uv_fall_input,
	input wire logic       ov_input,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       ara_request,
	input wire logic       direct_addressed,
	input wire logic       fet_on,
	input wire logic       power_good_out,
	input wire logic       alert_n,
	input wire logic       ara_reply_valid,
	input wire logic [6:0] ara_reply_addr
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_uv;
		(!uv_rise_input && !uv_fall_input)[*5];
	endsequence
	property p_rst_out;
		$fell(sys_rst) |-> alert_n && !fet_on && !power_good_out;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
	property p_uv_fet;
		s_uv |-> !fet_on;
	endproperty
	a_uv_fet: assert property (p_uv_fet) else $error("fet on during undervoltage");
	property p_uv_pg;
		s_uv |-> !power_good_out;
	endproperty
	a_uv_pg: assert property (p_uv_pg) else $error("power good during undervoltage");
	property p_ov_fet;
		ov_input[*5] |-> !fet_on;
	endproperty
	a_ov_fet: assert property (p_ov_fet) else $error("fet on during overvoltage");
	property p_ctl_off;
		reg_wr && reg_addr == 2'h3 && !reg_wdata[3] |-> ##[1:3] !fet_on;
	endproperty
	a_ctl_off: assert property (p_ctl_off) else $error("fet stays on after control off");
	property p_ara;
		ara_request && !alert_n |=> ara_reply_valid && alert_n;
	endproperty
	a_ara: assert property (p_ara) else $error("no reply or alert kept low");
	property p_addr;
		ara_reply_valid |-> ara_reply_addr == OWN_ADDR;
	endproperty
	a_addr: assert property (p_addr) else $error("wrong reply address");
	property p_direct;
		direct_addressed |=> alert_n;
	endproperty
	a_direct: assert property (p_direct) else $error("alert kept after direct access");
	c_alert: cover property ($fell(alert_n));
	c_reply: cover property (ara_reply_valid);
	c_fet: cover property ($rose(fet_on));
endmodule // fsa_sva
bind fsa_supervisor fsa_sva #(.OWN_ADDR(OWN_ADDR)) u_sva (
	.sys_clk, .sys_rst, .uv_rise_input, .uv_fall_input, .ov_input,
	.reg_addr, .reg_wdata, .reg_wr, .ara_request, .direct_addressed,
	.fet_on, .power_good_out, .alert_n, .ara_reply_valid, .ara_reply_addr
);
`default_nettype wire

// ==== verification/fsa_host_model.sv ====
// Purpose: Bus host that answers alerts with the alert response address.
// Assumes: Same clock as the supervisor.
// Notes: answer_dly sets how slowly the host reacts.
`timescale 1ns/1ps
`default_nettype none
module fsa_host_model (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       answer_en,
	input  wire logic [3:0] answer_dly,
	input  wire logic       alert_n,
	input  wire logic       ara_reply_valid,
	input  wire logic [6:0] ara_reply_addr,
	output var  logic       ara_request,
	output var  logic [6:0] got_addr,
	output var  logic [7:0] reply_cnt
);
	logic [3:0] wait_r;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ara_request <= 1'b0;
			wait_r <= 4'h0;
			got_addr <= 7'h00;
			reply_cnt <= 8'h00;
		end else begin
			if (ara_reply_valid) begin
				got_addr <= ara_reply_addr;
				reply_cnt <= reply_cnt + 8'h01;
			end
			// No second broadcast while the first is being answered.
			if (!alert_n && answer_en && !ara_request) begin
				if (wait_r == answer_dly) begin
					ara_request <= 1'b1;
					wait_r <= 4'h0;
				end else begin
					ara_request <= 1'b0;
					wait_r <= wait_r + 4'h1;
				end
			end else begin
				ara_request <= 1'b0;
				wait_r <= 4'h0;
			end
		end
	end
endmodule // fsa_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Register-level tests of fsa_supervisor.
// Assumes: BASE_DELAY shortened to 10 cycles.
// Notes: Pin levels need a few cycles to pass the sync flops.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       sys_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       uv_rise_input = 1'b1, uv_fall_input = 1'b1, uv_reset_level = 1'b1;
	logic       supply_ok = 1'b1, ext_fault_in = 1'b1, answer_en = 1'b1;
	logic       ov_input = 1'b0, on_input = 1'b0, enable_n = 1'b0, good_check_in = 1'b0;
	logic       second_good_pin = 1'b0, breaker_expired = 1'b0, sense_valid = 1'b0;
	logic       direct_addressed = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       ara_request, fet_on, power_good_out, alert_n, ara_reply_valid;
	logic [9:0] sense_reading = 10'h000;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [3:0] answer_dly = 4'h0;
	logic [7:0] reg_rdata, reply_cnt;
	logic [6:0] ara_reply_addr, got_addr;
	int         miscompares = 0;
	int         compares = 0;
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	fsa_supervisor #(.BASE_DELAY(10), .OWN_ADDR(7'h40)) u_dut (
		.sys_clk, .sys_rst, .uv_rise_input, .uv_fall_input, .uv_reset_level,
		.ov_input, .supply_ok, .on_input, .enable_n, .good_check_in,
		.second_good_pin, .ext_fault_in, .breaker_expired, .sense_valid,
		.sense_reading, .ara_request, .direct_addressed, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .fet_on, .power_good_out, .alert_n,
		.ara_reply_valid, .ara_reply_addr
	);
	fsa_host_model u_host (
		.sys_clk, .sys_rst, .answer_en, .answer_dly, .alert_n, .ara_reply_valid,
		.ara_reply_addr, .ara_request, .got_addr, .reply_cnt
	);
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// Read data stand in this cycle; the value seen at the edge is the settled one.
		@(posedge sys_clk);
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic wfet(input logic e, input int n);
		for (int i = 0; i < n && fet_on !== e; i++) @(posedge sys_clk);
		chk("fet_on", {7'h00, e}, {7'h00, fet_on});
	endtask
	task automatic sense(input logic [9:0] v);
		@(posedge sys_clk);
		sense_reading <= v;
		sense_valid <= 1'b1;
		@(posedge sys_clk);
		sense_valid <= 1'b0;
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(4);
		sys_rst <= 1'b0;
		cyc(4);
		rd(2'h2, 8'h00);
		wr(2'h3, 8'h08);
		wfet(1'b1, 40);
		good_check_in <= 1'b1;
		cyc(2);
		chk("power_good_out", 8'h01, {7'h00, power_good_out});
		wfet(1'b0, 80);
		rd(2'h1, 8'h08);
		rd(2'h0, 8'h00);
		good_check_in <= 1'b0;
		cyc(60);
		chk("fet_on", 8'h00, {7'h00, fet_on});
		wr(2'h1, 8'h00);
		wfet(1'b1, 40);
		uv_rise_input <= 1'b0;
		uv_fall_input <= 1'b0;
		wfet(1'b0, 20);
		chk("power_good_out", 8'h00, {7'h00, power_good_out});
		rd(2'h0, 8'h02);
		wr(2'h1, 8'h00);
		rd(2'h1, 8'h02);
		uv_rise_input <= 1'b1;
		cyc(8);
		rd(2'h0, 8'h02);
		uv_fall_input <= 1'b1;
		cyc(8);
		rd(2'h0, 8'h00);
		cyc(40);
		chk("fet_on", 8'h00, {7'h00, fet_on});
		wr(2'h1, 8'h00);
		cyc(5);
		chk("fet_on", 8'h00, {7'h00, fet_on});
		wfet(1'b1, 40);
		ov_input <= 1'b1;
		wfet(1'b0, 20);
		cyc(4);
		ov_input <= 1'b0;
		cyc(30);
		chk("fet_on", 8'h00, {7'h00, fet_on});
		wr(2'h1, 8'h00);
		wfet(1'b1, 4);
		// Earlier faults had no enable, so the host must not have been called.
		chk("reply_cnt", 8'h00, reply_cnt);
		wr(2'h2, 8'h80);
		ext_fault_in <= 1'b0;
		cyc(30);
		chk("reply_cnt", 8'h01, reply_cnt);
		chk("got_addr", 8'h40, {1'b0, got_addr});
		chk("alert_n", 8'h01, {7'h00, alert_n});
		chk("fet_on", 8'h01, {7'h00, fet_on});
		rd(2'h1, 8'h80);
		cyc(30);
		chk("reply_cnt", 8'h01, reply_cnt);
		ext_fault_in <= 1'b1;
		answer_dly <= 4'h5;
		cyc(4);
		wr(2'h1, 8'h00);
		ext_fault_in <= 1'b0;
		cyc(40);
		chk("reply_cnt", 8'h02, reply_cnt);
		answer_en <= 1'b0;
		ext_fault_in <= 1'b1;
		cyc(4);
		wr(2'h1, 8'h00);
		ext_fault_in <= 1'b0;
		cyc(8);
		chk("alert_n", 8'h00, {7'h00, alert_n});
		direct_addressed <= 1'b1;
		cyc(1);
		direct_addressed <= 1'b0;
		cyc(1);
		chk("alert_n", 8'h01, {7'h00, alert_n});
		ext_fault_in <= 1'b1;
		cyc(4);
		wr(2'h3, 8'h00);
		wfet(1'b0, 10);
		rd(2'h1, 8'h00);
		sense(10'h01F);
		rd(2'h1, 8'h00);
		sense(10'h020);
		rd(2'h1, 8'h20);
		wr(2'h3, 8'h20);
		second_good_pin <= 1'b1;
		cyc(6);
		rd(2'h1, 8'h60);
		wr(2'h2, 8'h40);
		rd(2'h2, 8'h00);
		sense(10'h000);
		second_good_pin <= 1'b0;
		enable_n <= 1'b1;
		cyc(6);
		rd(2'h0, 8'h10);
		rd(2'h1, 8'h70);
		enable_n <= 1'b0;
		cyc(6);
		rd(2'h1, 8'h10);
		supply_ok <= 1'b0;
		uv_rise_input <= 1'b0;
		uv_fall_input <= 1'b0;
		cyc(6);
		rd(2'h1, 8'h00);
		supply_ok <= 1'b1;
		cyc(6);
		rd(2'h1, 8'h02);
		uv_reset_level <= 1'b0;
		cyc(6);
		rd(2'h1, 8'h00);
		uv_reset_level <= 1'b1;
		cyc(6);
		rd(2'h1, 8'h02);
		uv_rise_input <= 1'b1;
		uv_fall_input <= 1'b1;
		cyc(6);
		wr(2'h1, 8'h00);
		wr(2'h3, 8'h0C);
		wfet(1'b1, 40);
		breaker_expired <= 1'b1;
		cyc(1);
		breaker_expired <= 1'b0;
		wfet(1'b0, 6);
		rd(2'h1, 8'h04);
		cyc(20);
		chk("fet_on", 8'h00, {7'h00, fet_on});
		wfet(1'b1, 60);
		rd(2'h1, 8'h04);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
